// File: rtl/fslr_core.sv
// Flash security interlock with test-port lockout recovery.
// Assumes security bytes and key come from the flash array on this clock.
`timescale 1ns/100ps
module fslr_core #(
    parameter int BSR_W = 8,
    parameter int ERASE_TICKS = 64,
    parameter logic [31:0] ID_CODE = 32'h1000_0001 // Arbitrary value
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic [7:0] sec_byte_lo,
    input wire logic [7:0] sec_byte_hi,
    input wire logic [15:0] flash_key,
    input wire logic [BSR_W-1:0] bsr_pins,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic tdo,
    output logic tdo_oe_n,
    output logic debug_read_inhibit,
    output logic emulation_enable,
    output logic secure_mode,
    output logic mass_erase,
    output logic erase_tick
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] pin_s1_reg, pin_s2_reg;
    logic tck_d_reg;
    logic tck_rise, tck_fall, tms_s, tdi_s, trst_s_n;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            // Reset matches the idle pins (test clock high) so no false edge follows
            pin_s1_reg <= 4'h9;
            pin_s2_reg <= 4'h9;
            tck_d_reg <= 1'b1;
        end else begin
            pin_s1_reg <= {trst_n, tdi, tms, tck};
            pin_s2_reg <= pin_s1_reg;
            tck_d_reg <= pin_s2_reg[0];
        end
    end

    always_comb begin
        tck_rise = pin_s2_reg[0] && !tck_d_reg;
        tck_fall = !pin_s2_reg[0] && tck_d_reg;
        tms_s = pin_s2_reg[1];
        tdi_s = pin_s2_reg[2];
        trst_s_n = pin_s2_reg[3];
    end

    // ****************************************************************
    // Test access port
    // ****************************************************************
    fslr_pkg::fslr_tap_t tap_reg, tap_next;
    logic [3:0] ir_reg, ir_next, irsh_reg, irsh_next;
    logic [31:0] dr_reg, dr_next;
    logic [6:0] jdiv_reg, jdiv_next;
    logic loaded_reg, loaded_next, tdo_next, oe_n_next;

    always_comb begin
        tap_next = tap_reg;
        ir_next = ir_reg;
        irsh_next = irsh_reg;
        dr_next = dr_reg;
        jdiv_next = jdiv_reg;
        loaded_next = loaded_reg;
        tdo_next = tdo;
        oe_n_next = tdo_oe_n;
        if (!trst_s_n) begin
            tap_next = fslr_pkg::FSLR_RESET;
            ir_next = fslr_pkg::IR_IDCODE;
            loaded_next = 1'b0;
        end else if (tck_rise) begin
            case (tap_reg)
                fslr_pkg::FSLR_RESET: tap_next = tms_s ? fslr_pkg::FSLR_RESET : fslr_pkg::FSLR_IDLE;
                fslr_pkg::FSLR_IDLE: tap_next = tms_s ? fslr_pkg::FSLR_SEL_DR : fslr_pkg::FSLR_IDLE;
                fslr_pkg::FSLR_SEL_DR: tap_next = tms_s ? fslr_pkg::FSLR_SEL_IR : fslr_pkg::FSLR_CAP_DR;
                fslr_pkg::FSLR_CAP_DR: tap_next = tms_s ? fslr_pkg::FSLR_EX1_DR : fslr_pkg::FSLR_SH_DR;
                fslr_pkg::FSLR_SH_DR: tap_next = tms_s ? fslr_pkg::FSLR_EX1_DR : fslr_pkg::FSLR_SH_DR;
                fslr_pkg::FSLR_EX1_DR: tap_next = tms_s ? fslr_pkg::FSLR_UPD_DR : fslr_pkg::FSLR_PAU_DR;
                fslr_pkg::FSLR_PAU_DR: tap_next = tms_s ? fslr_pkg::FSLR_EX2_DR : fslr_pkg::FSLR_PAU_DR;
                fslr_pkg::FSLR_EX2_DR: tap_next = tms_s ? fslr_pkg::FSLR_UPD_DR : fslr_pkg::FSLR_SH_DR;
                fslr_pkg::FSLR_UPD_DR: tap_next = tms_s ? fslr_pkg::FSLR_SEL_DR : fslr_pkg::FSLR_IDLE;
                fslr_pkg::FSLR_SEL_IR: tap_next = tms_s ? fslr_pkg::FSLR_RESET : fslr_pkg::FSLR_CAP_IR;
                fslr_pkg::FSLR_CAP_IR: tap_next = tms_s ? fslr_pkg::FSLR_EX1_IR : fslr_pkg::FSLR_SH_IR;
                fslr_pkg::FSLR_SH_IR: tap_next = tms_s ? fslr_pkg::FSLR_EX1_IR : fslr_pkg::FSLR_SH_IR;
                fslr_pkg::FSLR_EX1_IR: tap_next = tms_s ? fslr_pkg::FSLR_UPD_IR : fslr_pkg::FSLR_PAU_IR;
                fslr_pkg::FSLR_PAU_IR: tap_next = tms_s ? fslr_pkg::FSLR_EX2_IR : fslr_pkg::FSLR_PAU_IR;
                fslr_pkg::FSLR_EX2_IR: tap_next = tms_s ? fslr_pkg::FSLR_UPD_IR : fslr_pkg::FSLR_SH_IR;
                fslr_pkg::FSLR_UPD_IR: tap_next = tms_s ? fslr_pkg::FSLR_SEL_DR : fslr_pkg::FSLR_IDLE;
                default: tap_next = fslr_pkg::FSLR_RESET;
            endcase
            // Security state never gates these paths, so scan and ID stay available
            case (tap_reg)
                fslr_pkg::FSLR_RESET: ir_next = fslr_pkg::IR_IDCODE;
                fslr_pkg::FSLR_CAP_IR: irsh_next = fslr_pkg::IR_CAPTURE_VAL;
                fslr_pkg::FSLR_SH_IR: irsh_next = {tdi_s, irsh_reg[3:1]};
                fslr_pkg::FSLR_UPD_IR: ir_next = irsh_reg;
                fslr_pkg::FSLR_CAP_DR: begin
                    case (ir_reg)
                        fslr_pkg::IR_IDCODE: dr_next = ID_CODE;
                        fslr_pkg::IR_SAMPLE: dr_next = 32'(bsr_pins);
                        fslr_pkg::IR_LOCKOUT: dr_next = 32'(jdiv_reg);
                        default: dr_next = 32'h0000_0000;
                    endcase
                end
                fslr_pkg::FSLR_SH_DR: begin
                    case (ir_reg)
                        fslr_pkg::IR_IDCODE: dr_next = {tdi_s, dr_reg[31:1]};
                        fslr_pkg::IR_SAMPLE: dr_next[BSR_W-1:0] = {tdi_s, dr_reg[BSR_W-1:1]};
                        fslr_pkg::IR_LOCKOUT: dr_next[6:0] = {tdi_s, dr_reg[6:1]};
                        default: dr_next[0] = tdi_s;
                    endcase
                end
                fslr_pkg::FSLR_UPD_DR: begin
                    if (ir_reg == fslr_pkg::IR_LOCKOUT) begin
                        jdiv_next = dr_reg[6:0];
                        loaded_next = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (tck_fall) begin
            oe_n_next = !(tap_reg == fslr_pkg::FSLR_SH_DR || tap_reg == fslr_pkg::FSLR_SH_IR);
            tdo_next = (tap_reg == fslr_pkg::FSLR_SH_IR) ? irsh_reg[0] : dr_reg[0];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tap_reg <= fslr_pkg::FSLR_RESET;
            ir_reg <= fslr_pkg::IR_IDCODE;
            irsh_reg <= fslr_pkg::IR_CAPTURE_VAL;
            dr_reg <= 32'h0000_0000;
            jdiv_reg <= fslr_pkg::DIVIDER_RESET;
            loaded_reg <= 1'b0;
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else begin
            tap_reg <= tap_next;
            ir_reg <= ir_next;
            irsh_reg <= irsh_next;
            dr_reg <= dr_next;
            jdiv_reg <= jdiv_next;
            loaded_reg <= loaded_next;
            tdo <= tdo_next;
            tdo_oe_n <= oe_n_next;
        end
    end

    // ****************************************************************
    // Security, erase timing and register port
    // ****************************************************************
    logic booted_reg, booted_next, secured_reg, secured_next, backdoor_key_enable_reg, backdoor_key_enable_next;
    logic erasing_next, done_reg, done_next, tick_next, half_reg, half_next;
    logic rec_active, fin_en, pre_en;
    logic [6:0] div_reg, div_next, eff_div;
    logic [2:0] pre_reg, pre_next;
    logic [5:0] dcnt_reg, dcnt_next;
    logic [15:0] ecnt_reg, ecnt_next, rdata_next;

    always_comb begin
        booted_next = 1'b1;
        secured_next = secured_reg;
        backdoor_key_enable_next = backdoor_key_enable_reg;
        div_next = div_reg;
        done_next = done_reg;
        rdata_next = 16'h0000;
        // A slow boot capture keeps the port closed: reset state is secured
        if (!booted_reg) begin
            secured_next = (sec_byte_lo == fslr_pkg::SEC_ON_CODE);
            backdoor_key_enable_next = sec_byte_hi[fslr_pkg::KEY_EN_BIT];
        end
        rec_active = booted_reg && loaded_reg && !done_reg
            && ir_reg == fslr_pkg::IR_LOCKOUT && tap_reg == fslr_pkg::FSLR_IDLE;
        eff_div = rec_active ? jdiv_reg : div_reg;
        half_next = !half_reg;
        fin_en = half_reg;
        pre_next = pre_reg;
        pre_en = fin_en;
        if (eff_div[fslr_pkg::PRESCALE_BIT]) begin
            pre_en = fin_en && pre_reg == fslr_pkg::PRESCALE_LAST;
            if (fin_en) begin
                pre_next = pre_reg + 3'h1;
            end
        end
        dcnt_next = dcnt_reg;
        tick_next = 1'b0;
        if (pre_en) begin
            if (dcnt_reg >= eff_div[5:0]) begin
                dcnt_next = 6'h00;
                tick_next = 1'b1;
            end else begin
                dcnt_next = dcnt_reg + 6'h01;
            end
        end
        // Leaving Run-Test/Idle early abandons the erase and restarts the count
        erasing_next = rec_active;
        ecnt_next = rec_active ? ecnt_reg : 16'h0000;
        if (rec_active && tick_next) begin
            if (ecnt_reg == 16'(ERASE_TICKS - 1)) begin
                done_next = 1'b1;
                secured_next = 1'b0;
                erasing_next = 1'b0;
            end else begin
                ecnt_next = ecnt_reg + 16'h0001;
            end
        end
        if (wr) begin
            case (addr)
                fslr_pkg::ADDR_DIVIDER: div_next = wdata[6:0];
                fslr_pkg::ADDR_KEY: begin
                    if (backdoor_key_enable_reg && booted_reg && wdata == flash_key) begin
                        secured_next = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (addr)
                fslr_pkg::ADDR_DIVIDER: rdata_next = {9'h000, div_reg};
                fslr_pkg::ADDR_STATUS: rdata_next = {11'h000, booted_reg, done_reg,
                    mass_erase, backdoor_key_enable_reg, secured_reg};
                fslr_pkg::ADDR_JTAG_DIV: rdata_next = {9'h000, jdiv_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            booted_reg <= 1'b0;
            secured_reg <= 1'b1;
            backdoor_key_enable_reg <= 1'b0;
            div_reg <= fslr_pkg::DIVIDER_RESET;
            done_reg <= 1'b0;
            half_reg <= 1'b0;
            pre_reg <= 3'h0;
            dcnt_reg <= 6'h00;
            ecnt_reg <= 16'h0000;
            rdata <= 16'h0000;
            mass_erase <= 1'b0;
            erase_tick <= 1'b0;
            debug_read_inhibit <= 1'b1;
            emulation_enable <= 1'b0;
            secure_mode <= 1'b1;
        end else begin
            booted_reg <= booted_next;
            secured_reg <= secured_next;
            backdoor_key_enable_reg <= backdoor_key_enable_next;
            div_reg <= div_next;
            done_reg <= done_next;
            half_reg <= half_next;
            pre_reg <= pre_next;
            dcnt_reg <= dcnt_next;
            ecnt_reg <= ecnt_next;
            rdata <= rdata_next;
            mass_erase <= erasing_next;
            erase_tick <= tick_next;
            debug_read_inhibit <= secured_next;
            emulation_enable <= !secured_next;
            secure_mode <= secured_next;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_inhibit_follows_sec: assert property (@(posedge clock) disable iff (!nrst)
        $rose(booted_reg) |-> debug_read_inhibit
        == ($past(sec_byte_lo) == fslr_pkg::SEC_ON_CODE))
        else $error("inhibit differs from security bytes");
    a_emul_off_secure: assert property (@(posedge clock) disable iff (!nrst)
        secured_reg |-> !emulation_enable) else $error("emulation on while secured");
    a_boot_mode_pick: assert property (@(posedge clock) disable iff (!nrst)
        !booted_reg ##1 booted_reg |-> secure_mode
        == ($past(sec_byte_lo) == fslr_pkg::SEC_ON_CODE))
        else $error("boot mode not taken from bytes");
    a_id_capture: assert property (@(posedge clock) disable iff (!nrst)
        tck_rise && trst_s_n && tap_reg == fslr_pkg::FSLR_CAP_DR
        && ir_reg == fslr_pkg::IR_IDCODE |=> dr_reg == ID_CODE)
        else $error("ID not captured");
    a_jdiv_update: assert property (@(posedge clock) disable iff (!nrst)
        tck_rise && trst_s_n && tap_reg == fslr_pkg::FSLR_UPD_DR
        && ir_reg == fslr_pkg::IR_LOCKOUT |=> jdiv_reg == $past(dr_reg[6:0]) && loaded_reg)
        else $error("recovery divider not loaded");
    a_erase_only_idle: assert property (@(posedge clock) disable iff (!nrst)
        mass_erase |-> $past(tap_reg) == fslr_pkg::FSLR_IDLE
        && $past(ir_reg) == fslr_pkg::IR_LOCKOUT) else $error("erase outside idle");
    a_erase_clears_sec: assert property (@(posedge clock) disable iff (!nrst)
        $rose(done_reg) |-> !secured_reg && !debug_read_inhibit ##1 emulation_enable)
        else $error("erase did not clear security");
    a_tick_no_pre: assert property (@(posedge clock) disable iff (!nrst)
        erase_tick ##1 (eff_div == 7'h00) |-> ##1 erase_tick)
        else $error("tick spacing wrong");
    a_prescale_gap: assert property (@(posedge clock) disable iff (!nrst)
        tick_next && eff_div[6] |-> pre_reg == 3'h7 && half_reg)
        else $error("tick without prescale wrap");
    a_key_gated: assert property (@(posedge clock) disable iff (!nrst)
        wr && addr == 4'h2 && !backdoor_key_enable_reg && secured_reg && !rec_active |=> secured_reg)
        else $error("key unsecured with key disabled");

endmodule

// File: rtl/fslr_pkg.sv
// Constants shared by the flash security and lockout recovery block.
// Assumes one system clock; the test port pins arrive asynchronously.
package fslr_pkg;

    // ****************************************************************
    // Test access port
    // ****************************************************************
    localparam int IR_W = 4;
    localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
    localparam logic [3:0] IR_SAMPLE = 4'h1;
    localparam logic [3:0] IR_IDCODE = 4'h2;
    localparam logic [3:0] IR_LOCKOUT = 4'h8;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam int DR_W = 32;
    localparam int REC_DR_W = 7;

    typedef enum logic [3:0] {
        FSLR_RESET, FSLR_IDLE, FSLR_SEL_DR, FSLR_CAP_DR, FSLR_SH_DR, FSLR_EX1_DR,
        FSLR_PAU_DR, FSLR_EX2_DR, FSLR_UPD_DR, FSLR_SEL_IR, FSLR_CAP_IR, FSLR_SH_IR,
        FSLR_EX1_IR, FSLR_PAU_IR, FSLR_EX2_IR, FSLR_UPD_IR
    } fslr_tap_t;

    // ****************************************************************
    // Security bytes
    // ****************************************************************
    localparam logic [7:0] SEC_ON_CODE = 8'hA5;
    localparam int KEY_EN_BIT = 7;

    // ****************************************************************
    // Divider layout
    // ****************************************************************
    localparam int PRESCALE_BIT = 6;
    localparam int DIV_W = 6;
    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam logic [6:0] DIVIDER_RESET = 7'h00;

    // ****************************************************************
    // Register port
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] ADDR_DIVIDER = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_KEY = 4'h2;
    localparam logic [3:0] ADDR_JTAG_DIV = 4'h3;
    localparam int ST_SECURED = 0;
    localparam int ST_KEY_EN = 1;
    localparam int ST_ERASING = 2;
    localparam int ST_ERASED = 3;
    localparam int ST_BOOTED = 4;

endpackage

// File: tb/fslr_jtag_host.sv
// Behavioural test port host that walks the lockout recovery sequence.
// Assumes the block samples the test pins on its own system clock.
`timescale 1ns/100ps
module fslr_jtag_host (
    input wire logic clock,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n
);
    // ****************
    // Pin sequencing
    // ****************
    logic oe_bad = 1'b0;
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // Low 5 clocks, high 4: both phases stay above the synchroniser minimum
    task automatic step(input logic m, input logic d, input logic sh, output logic q);
        @(posedge clock);
        tck <= 1'b0;
        tms <= m;
        tdi <= sh ? d : ~tdi;
        repeat (5) @(posedge clock);
        q = tdo;
        if (sh && tdo_oe_n !== 1'b0) oe_bad = 1'b1;
        tck <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    task automatic tap_reset();
        logic q;
        @(posedge clock);
        trst_n <= 1'b0;
        repeat (4) @(posedge clock);
        trst_n <= 1'b1;
        repeat (3) @(posedge clock);
        repeat (5) step(1'b1, 1'b0, 1'b0, q);
        step(1'b0, 1'b0, 1'b0, q);
    endtask

    // Starts and ends in Run-Test/Idle; the test clock then stands still
    task automatic shift(input logic ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, 1'b0, q);
        if (ir) step(1'b1, 1'b0, 1'b0, q);
        step(1'b0, 1'b0, 1'b0, q);
        step(1'b0, 1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], 1'b1, q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, 1'b0, q);
        step(1'b0, 1'b0, 1'b0, q);
    endtask
endmodule

// File: tb/fslr_core_tb_top.sv
// Self-checking bench for the flash security interlock and recovery.
// Assumes the flash array is modelled by the security byte and key inputs.
`timescale 1ns/100ps
module fslr_core_tb_top;
    localparam logic [31:0] ID_VAL = 32'h2000_0003; // Arbitrary value
    localparam int TICKS = 4;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sec_lo = 8'hA5;
    logic [7:0] sec_hi = 8'h00;
    logic [15:0] flash_key = 16'h3C5A; // Key stored before the bytes lock
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe_n;
    logic inhibit, emul_en, secure, erasing, tick;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;

    initial begin
        forever #4 clock = ~clock;
    end

    fslr_core #(.BSR_W(8), .ERASE_TICKS(TICKS), .ID_CODE(ID_VAL)) DUT (
        .clock(clock), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .sec_byte_lo(sec_lo), .sec_byte_hi(sec_hi), .flash_key(flash_key),
        .bsr_pins(8'hC3), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n), .debug_read_inhibit(inhibit),
        .emulation_enable(emul_en), .secure_mode(secure), .mass_erase(erasing),
        .erase_tick(tick));

    fslr_jtag_host host (.clock(clock), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n));

    // ****************
    // Shared tasks
    // ****************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Ceiling sits well above the longest erase run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic boot(input logic [7:0] lo, input logic [7:0] hi);
        @(posedge clock);
        nrst <= 1'b0;
        sec_lo <= lo;
        sec_hi <= hi;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(negedge clock);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        repeat (2) @(negedge clock);
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask

    task automatic expect_mode(input logic sec, input logic [15:0] st);
        logic [15:0] d;
        check("inhibit", inhibit, sec);
        check("emulation", emul_en, !sec);
        reg_rd(fslr_pkg::ADDR_STATUS, d);
        check("status", d, st);
    endtask

    task automatic next_tick(output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (tick !== 1'b1 && n < 3000);
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_boot();
        logic [31:0] q;
        check("rst_inhibit", inhibit, 1'b1);
        check("rst_mode", secure, 1'b1);
        boot(fslr_pkg::SEC_ON_CODE, 8'h00);
        check("boot_mode", secure, 1'b1);
        expect_mode(1'b1, 16'h0011);
        host.tap_reset();
        host.shift(1'b0, 32, 32'h0, q);
        check("idcode", q, ID_VAL);
        host.shift(1'b1, fslr_pkg::IR_W, {28'h0, fslr_pkg::IR_SAMPLE}, q);
        host.shift(1'b0, 8, 32'h0, q);
        check("sample", q[7:0], 8'hC3);
    endtask

    task automatic t_regs();
        logic [15:0] d;
        int n;
        reg_wr(fslr_pkg::ADDR_DIVIDER, 16'h004A);
        reg_rd(fslr_pkg::ADDR_DIVIDER, d);
        check("divider", d, 16'h004A);
        next_tick(n);
        next_tick(n);
        check("reg_period", n, 176);
        reg_wr(4'h7, flash_key);
        reg_rd(4'h7, d);
        check("unmapped", d, 16'h0000);
        reg_wr(fslr_pkg::ADDR_KEY, flash_key);
        expect_mode(1'b1, 16'h0011);
    endtask

    task automatic t_key();
        boot(fslr_pkg::SEC_ON_CODE, 8'h80);
        reg_wr(fslr_pkg::ADDR_KEY, ~flash_key);
        expect_mode(1'b1, 16'h0013);
        reg_wr(fslr_pkg::ADDR_KEY, flash_key);
        expect_mode(1'b0, 16'h0012);
    endtask

    task automatic t_recover(input logic [6:0] div, input logic abort);
        logic [31:0] q;
        logic [15:0] d;
        int period;
        int n;
        period = (int'(div[5:0]) + 1) * 2 * (div[6] ? 8 : 1);
        boot(fslr_pkg::SEC_ON_CODE, 8'h00);
        host.tap_reset();
        host.shift(1'b1, fslr_pkg::IR_W, {28'h0, fslr_pkg::IR_LOCKOUT}, q);
        check("ir_capture", q[3:0], fslr_pkg::IR_CAPTURE_VAL);
        repeat (3) @(negedge clock);
        check("no_early_erase", erasing, 1'b0);
        host.shift(1'b0, fslr_pkg::REC_DR_W, {25'h0, div}, q);
        repeat (3) @(negedge clock);
        check("erase_on", erasing, 1'b1);
        reg_rd(fslr_pkg::ADDR_JTAG_DIV, d);
        check("jtag_div", d, {9'h0, div});
        next_tick(n);
        next_tick(n);
        check("tick_period", n, period);
        if (abort) begin
            host.step(1'b1, 1'b0, 1'b0, q[0]);
            repeat (2) @(negedge clock);
            check("abort_stop", erasing, 1'b0);
            expect_mode(1'b1, 16'h0011);
        end else begin
            n = 0;
            while (erasing === 1'b1 && n < TICKS * period) begin
                @(negedge clock);
                n++;
            end
            check("erase_end", erasing, 1'b0);
            @(negedge clock);
            expect_mode(1'b0, 16'h0018);
        end
    endtask

    task automatic t_return();
        logic [31:0] q;
        boot(8'hFF, 8'hFF);
        check("user_mode", secure, 1'b0);
        host.tap_reset();
        expect_mode(1'b0, 16'h0012);
        host.shift(1'b0, 32, 32'h0, q);
        check("idcode_after", q, ID_VAL);
        host.shift(1'b1, fslr_pkg::IR_W, {28'h0, fslr_pkg::IR_BYPASS}, q);
        host.shift(1'b0, 2, 32'h3, q);
        check("bypass", q[1:0], 2'b10);
        check("tdo_enable", host.oe_bad, 1'b0);
        check("tdo_idle", tdo_oe_n, 1'b1);
    endtask

    initial begin
        @(negedge clock);
        t_boot();
        t_regs();
        t_key();
        t_recover(7'h6D, 1'b0);
        t_recover(7'h45, 1'b1);
        t_recover(7'h05, 1'b0);
        t_return();
        wrap_up();
    end
endmodule
